// ===== hw/cpu_mem_consts.svh
// Constants of the core program-counter, return-stack and indirect-pointer logic.
// Contract
// - Return stack holds sixteen 15-bit entries, kept apart from data memory.
// - Overflow and underflow set sticky flags; optional software reset on either.
// - Two 16-bit indirect pointers reach all file registers and program memory.
// - Indirect access to program memory takes one extra instruction cycle.
// - Pointers offer a linear, unbanked view of general-purpose RAM.
// - Program counter is 15 bits wide, a 32K-word space of 14-bit words.
// - Program addresses beyond the implemented size wrap into it.
// - Reset loads the program counter with 0000h; interrupts vector to 0004h.
// - Top 128 words form the high-endurance region, low byte only.
// - Pointer high-byte bit 7 set makes the data port read program memory.
// - Indirect program read returns the word's low eight bits.
// - Indirect writes to program memory addresses have no effect.
// - Interrupt entry saves core context to shadows; return restores it.
// - Decoder supports exactly 49 instructions, pointer instructions included.
// - Data addresses are 12 bits: five bank bits, seven offset bits.
`ifndef CPU_MEM_CONSTS_SVH
`define CPU_MEM_CONSTS_SVH

`define PC_RESET_VEC  15'h0000
`define PC_IRQ_VEC    15'h0004
`define STACK_DEPTH   5'h10
`define PROG_WORDS    2048
`define HEF_WORDS     128
`define INSTR_COUNT   49
`define PTR_PFM_BIT   15
`define LIN_TAG       3'h1
`define LIN_GPR_BYTES 13'h0050
`define GPR_BASE      7'h20

`endif

// ===== hw/cpu_mem_pkg.sv
// Types shared by the core memory access logic.
`default_nettype none
package cpu_mem_pkg;
	typedef logic [14:0] pc_t;
	typedef logic [15:0] ptr_t;
	typedef logic [11:0] daddr_t;
	typedef enum logic [1:0] {
		IND_IDLE = 2'b00,
		IND_DMEM = 2'b01,
		IND_PFMA = 2'b10,
		IND_PFMB = 2'b11
	} ind_state_t;
endpackage
`default_nettype wire

// ===== hw/ret_stack_mem.sv
// Return-address memory with registered, write-first read port.
`default_nettype none
module ret_stack_mem #(
	parameter int W  = 15,
	parameter int AW = 4
) (
	input  wire logic          i_clk_sys,
	input  wire logic          i_ce,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [W-1:0]  o_rdata
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_clk_sys) begin
		if (i_ce && i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_ce) begin
			if (i_we && i_waddr == i_raddr) begin
				o_rdata <= i_wdata;
			end else begin
				o_rdata <= mem[i_raddr];
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/cpu_mem_access.sv
// Program counter, return stack, shadow context and indirect pointer access of the core.
`include "cpu_mem_consts.svh"
`default_nettype none
module cpu_mem_access #(
	parameter int PROG_WORDS = `PROG_WORDS,
	parameter int CTX_W      = 32
) (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_ce,
	input  wire logic                   i_pc_inc,
	input  wire logic                   i_pc_load,
	input  wire logic                   i_call,
	input  wire logic                   i_ret,
	input  wire logic                   i_retfie,
	input  wire logic                   i_irq_take,
	input  wire cpu_mem_pkg::pc_t       i_pc_target,
	output cpu_mem_pkg::pc_t            o_pc,
	input  wire logic                   i_stk_err_rst_en,
	input  wire logic                   i_clr_ovf,
	input  wire logic                   i_clr_unf,
	output logic                        o_stack_overflow_flag,
	output logic                        o_stack_underflow_flag,
	output logic                        o_soft_reset,
	input  wire logic [CTX_W-1:0]       i_ctx,
	output logic      [CTX_W-1:0]       o_ctx_restore,
	output logic                        o_ctx_restore_valid,
	input  wire logic                   i_ptr_wr,
	input  wire logic                   i_ptr_wsel,
	input  wire logic                   i_ptr_whigh,
	input  wire logic [7:0]             i_ptr_wdata,
	output cpu_mem_pkg::ptr_t           o_ptr0,
	output cpu_mem_pkg::ptr_t           o_ptr1,
	input  wire logic                   i_ind_req,
	input  wire logic                   i_ind_sel,
	input  wire logic                   i_ind_we,
	input  wire logic [7:0]             i_ind_wdata,
	output logic                        o_ind_ready,
	output logic [7:0]                  o_ind_rdata,
	output logic                        o_ind_done,
	output logic                        o_ind_wr_ignored,
	output cpu_mem_pkg::daddr_t         o_dmem_addr,
	output logic                        o_dmem_rd,
	output logic                        o_dmem_we,
	output logic [7:0]                  o_dmem_wdata,
	input  wire logic [7:0]             i_dmem_rdata,
	output cpu_mem_pkg::pc_t            o_pfm_addr,
	output logic                        o_pfm_rd,
	output logic                        o_pfm_hef,
	input  wire logic [13:0]            i_pfm_rdata
);
	import cpu_mem_pkg::*;

	// ---------------------------------------------------------------
	// Address helpers
	// ---------------------------------------------------------------
	localparam pc_t PC_MASK  = pc_t'(PROG_WORDS - 1);
	localparam pc_t HEF_BASE = pc_t'(PROG_WORDS - `HEF_WORDS);
	// The decoder serving this block offers this many instructions.
	localparam int  N_INSTR  = `INSTR_COUNT;

	function automatic pc_t pc_wrap(input logic [15:0] a);
		pc_wrap = a[14:0] & PC_MASK;
	endfunction

	// Linear GPR space: consecutive 80-byte blocks of each bank's GPR area.
	function automatic daddr_t data_map(input ptr_t p);
		logic [12:0] bank;
		logic [12:0] loc;
		bank = p[12:0] / `LIN_GPR_BYTES;
		loc  = p[12:0] - 13'(bank * `LIN_GPR_BYTES);
		if (p[15:13] == `LIN_TAG) begin
			data_map = {bank[4:0], `GPR_BASE + loc[6:0]};
		end else begin
			data_map = p[11:0];
		end
	endfunction

	// ---------------------------------------------------------------
	// Stack control
	// ---------------------------------------------------------------
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [3:0]  top_idx;
	pc_t         top_q;
	pc_t         push_val;
	logic        do_irq;
	logic        do_pop;
	logic        do_call;
	logic        do_push;
	logic        ovf_evt;
	logic        unf_evt;
	logic        err_rst;
	logic        stk_we;
	logic [CTX_W-1:0] shadow;

	always_comb begin
		do_irq   = i_irq_take;
		do_pop   = !do_irq && (i_ret || i_retfie);
		do_call  = !do_irq && !do_pop && i_call;
		do_push  = do_irq || do_call;
		ovf_evt  = do_push && cnt == `STACK_DEPTH;
		unf_evt  = do_pop && cnt == 5'h00;
		err_rst  = i_stk_err_rst_en && (ovf_evt || unf_evt);
		stk_we   = do_push && !ovf_evt;
		push_val = do_irq ? o_pc : pc_wrap({1'b0, o_pc} + 16'h0001);
		if (err_rst) begin
			next_cnt = 5'h00;
		end else if (stk_we) begin
			next_cnt = cnt + 5'h01;
		end else if (do_pop && !unf_evt) begin
			next_cnt = cnt - 5'h01;
		end else begin
			next_cnt = cnt;
		end
		top_idx = 4'(next_cnt - 5'h01);
	end

	ret_stack_mem #(.W(15), .AW(4)) u_stack (
		.i_clk_sys (i_clk_sys),
		.i_ce      (i_ce),
		.i_we      (stk_we),
		.i_waddr   (cnt[3:0]),
		.i_wdata   (push_val),
		.i_raddr   (top_idx),
		.o_rdata   (top_q)
	);

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= 5'h00;
		end else if (i_ce) begin
			cnt <= next_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Program counter
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pc <= `PC_RESET_VEC;
		end else if (i_ce) begin
			if (err_rst) begin
				o_pc <= `PC_RESET_VEC;
			end else if (do_irq) begin
				o_pc <= `PC_IRQ_VEC;
			end else if (do_pop) begin
				o_pc <= unf_evt ? `PC_RESET_VEC : pc_wrap({1'b0, top_q});
			end else if (do_call || i_pc_load) begin
				o_pc <= pc_wrap({1'b0, i_pc_target});
			end else if (i_pc_inc) begin
				o_pc <= pc_wrap({1'b0, o_pc} + 16'h0001);
			end
		end
	end

	// ---------------------------------------------------------------
	// Reset cause flags and software reset
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_stack_overflow_flag  <= 1'b0;
			o_stack_underflow_flag <= 1'b0;
			o_soft_reset           <= 1'b0;
		end else if (i_ce) begin
			// A new event wins over a clear in the same cycle.
			o_stack_overflow_flag  <= ovf_evt || (o_stack_overflow_flag && !i_clr_ovf);
			o_stack_underflow_flag <= unf_evt || (o_stack_underflow_flag && !i_clr_unf);
			o_soft_reset           <= err_rst;
		end
	end

	// ---------------------------------------------------------------
	// Shadow context
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shadow              <= '0;
			o_ctx_restore       <= '0;
			o_ctx_restore_valid <= 1'b0;
		end else if (i_ce) begin
			if (do_irq) begin
				shadow <= i_ctx;
			end
			o_ctx_restore_valid <= do_pop && i_retfie;
			if (do_pop && i_retfie) begin
				o_ctx_restore <= shadow;
			end
		end
	end

	// ---------------------------------------------------------------
	// Indirect pointers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ptr0 <= 16'h0000;
			o_ptr1 <= 16'h0000;
		end else if (i_ce && i_ptr_wr) begin
			if (!i_ptr_wsel && i_ptr_whigh) o_ptr0[15:8] <= i_ptr_wdata;
			if (!i_ptr_wsel && !i_ptr_whigh) o_ptr0[7:0] <= i_ptr_wdata;
			if (i_ptr_wsel && i_ptr_whigh) o_ptr1[15:8] <= i_ptr_wdata;
			if (i_ptr_wsel && !i_ptr_whigh) o_ptr1[7:0] <= i_ptr_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Indirect data port
	// ---------------------------------------------------------------
	ind_state_t state;
	ptr_t       ind_ptr;
	logic       ind_pfm;
	logic       ind_go;
	logic       pend_we;

	always_comb begin
		ind_ptr     = i_ind_sel ? o_ptr1 : o_ptr0;
		ind_pfm     = ind_ptr[`PTR_PFM_BIT];
		o_ind_ready = state == IND_IDLE;
		ind_go      = i_ind_req && o_ind_ready;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state            <= IND_IDLE;
			pend_we          <= 1'b0;
			o_dmem_addr      <= 12'h000;
			o_dmem_rd        <= 1'b0;
			o_dmem_we        <= 1'b0;
			o_dmem_wdata     <= 8'h00;
			o_pfm_addr       <= 15'h0000;
			o_pfm_rd         <= 1'b0;
			o_pfm_hef        <= 1'b0;
			o_ind_rdata      <= 8'h00;
			o_ind_done       <= 1'b0;
			o_ind_wr_ignored <= 1'b0;
		end else if (i_ce) begin
			o_dmem_rd        <= 1'b0;
			o_dmem_we        <= 1'b0;
			o_pfm_rd         <= 1'b0;
			o_ind_done       <= 1'b0;
			o_ind_wr_ignored <= 1'b0;
			case (state)
				IND_IDLE: begin
					if (ind_go) begin
						pend_we <= i_ind_we;
						if (ind_pfm) begin
							o_pfm_addr <= pc_wrap({1'b0, ind_ptr[14:0]});
							o_pfm_hef  <= pc_wrap({1'b0, ind_ptr[14:0]}) >= HEF_BASE;
							o_pfm_rd   <= !i_ind_we;
							state      <= IND_PFMA;
						end else begin
							o_dmem_addr  <= data_map(ind_ptr);
							o_dmem_rd    <= !i_ind_we;
							o_dmem_we    <= i_ind_we;
							o_dmem_wdata <= i_ind_wdata;
							state        <= IND_DMEM;
						end
					end
				end
				IND_DMEM: begin
					o_ind_rdata <= pend_we ? 8'h00 : i_dmem_rdata;
					o_ind_done  <= 1'b1;
					state       <= IND_IDLE;
				end
				IND_PFMA: begin
					state <= IND_PFMB;
				end
				IND_PFMB: begin
					o_ind_rdata      <= pend_we ? 8'h00 : i_pfm_rdata[7:0];
					o_ind_done       <= 1'b1;
					o_ind_wr_ignored <= pend_we;
					state            <= IND_IDLE;
				end
				default: begin
					state <= IND_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	AST_DEPTH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		cnt <= `STACK_DEPTH) else $error("stack count above depth");
	AST_CALL_RET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && do_call && cnt < `STACK_DEPTH) ##1 (i_ce && i_ret && !i_irq_take)
		|=> o_pc == pc_wrap({1'b0, $past(o_pc, 2)} + 16'h0001))
		else $error("return did not resume after call");
	AST_OVF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && do_push && cnt == `STACK_DEPTH) |=> o_stack_overflow_flag
		&& (o_soft_reset == $past(i_stk_err_rst_en))) else $error("overflow missed");
	AST_UNF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && do_pop && cnt == 5'h00) |=> o_stack_underflow_flag
		&& (o_soft_reset == $past(i_stk_err_rst_en))) else $error("underflow missed");
	AST_SOFT_RST_PC: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_soft_reset |-> o_pc == `PC_RESET_VEC && cnt == 5'h00)
		else $error("software reset left state");
	AST_IRQ_VEC: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && i_irq_take && !err_rst) |=> o_pc == `PC_IRQ_VEC)
		else $error("interrupt vector wrong");
	AST_PC_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		((o_pc & ~PC_MASK) == 15'h0000) && ((o_pfm_addr & ~PC_MASK) == 15'h0000))
		else $error("address outside implemented memory");
	AST_PFM_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && ind_go && ind_pfm && !i_ind_we) |=> o_pfm_rd && !o_dmem_rd && !o_dmem_we)
		else $error("pointer bit 7 did not select program memory");
	AST_PFM_LAT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && ind_go && ind_pfm) ##1 (i_ce && !o_ind_done) ##1 (i_ce && !o_ind_done)
		|=> o_ind_done) else $error("program read latency wrong");
	AST_DMEM_LAT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && ind_go && !ind_pfm) ##1 (i_ce && !o_ind_done) |=> o_ind_done)
		else $error("data access latency wrong");
	AST_PFM_NOWR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && ind_go && ind_pfm && i_ind_we) |=> (!o_pfm_rd && !o_dmem_we)[*3])
		else $error("program memory write leaked");
	AST_LOW_BYTE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state == IND_PFMB && !pend_we) |=> o_ind_rdata == $past(i_pfm_rdata[7:0]))
		else $error("program read byte wrong");
	AST_RESTORE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && do_pop && i_retfie) |=> o_ctx_restore_valid && o_ctx_restore == $past(shadow))
		else $error("context not restored");

	COV_IRQ_RETFIE: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_ctx_restore_valid);
	COV_PFM_READ: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_ind_done && !o_ind_wr_ignored && $past(state) == IND_PFMB);
	COV_OVF: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		$rose(o_stack_overflow_flag));
	COV_LINEAR: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		i_ce && ind_go && ind_ptr[15:13] == `LIN_TAG);
endmodule
`default_nettype wire

// ===== testbench/mem_partner.sv
// Behavioural program flash array and data memory behind the indirect port.
`default_nettype none
module mem_partner (
	input  wire logic                i_clk_sys,
	input  wire cpu_mem_pkg::daddr_t i_dmem_addr,
	input  wire logic                i_dmem_rd,
	output logic [7:0]               o_dmem_rdata,
	input  wire cpu_mem_pkg::pc_t    i_pfm_addr,
	input  wire logic                i_pfm_rd,
	output logic [13:0]              o_pfm_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import cpu_mem_pkg::*;
	logic [7:0] churn;
	initial begin
		churn = 8'h00;
		o_pfm_rdata = 14'h0000;
	end
	always @(posedge i_clk_sys) begin
		churn <= churn + 8'h3b;
	end
	// Data is valid only in the strobe cycle; outside it the bus churns so stale data fails.
	assign o_dmem_rdata = i_dmem_rd ? (i_dmem_addr[7:0] ^ 8'h5a) : churn;
	// The flash word arrives the cycle after the strobe, then flips to its inverse.
	always @(posedge i_clk_sys) begin
		if (i_pfm_rd) begin
			o_pfm_rdata <= i_pfm_addr[13:0] ^ 14'h2c95;
		end else begin
			o_pfm_rdata <= ~o_pfm_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the program counter, return stack and indirect port.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cpu_mem_pkg::*;
	localparam int PW = 1024;
	localparam logic [5:0] K_INC = 6'h01, K_LOAD = 6'h02, K_CALL = 6'h04;
	localparam logic [5:0] K_RET = 6'h08, K_RETFIE = 6'h10, K_IRQ = 6'h20;
	logic clk, rst_b, ce, inc, load, call, ret, retfie, irq, err_en, clr_ovf, clr_unf;
	logic ovf, unf, srst, ctx_v, pwr, pwsel, pwhigh, req, isel, iwe, rdy, done, wign;
	logic drd, dwe, prd, phef;
	pc_t target, pc, paddr, c1_paddr;
	ptr_t p0, p1;
	daddr_t daddr, c1_daddr;
	logic [31:0] ctx, ctx_r;
	logic [7:0] pwdata, iwdata, rdata, dwdata, drdata, c1_dw;
	logic [13:0] prdata;
	logic [3:0] c1;
	logic c1_rdy;
	int errors, compares, cyc, lat;

	cpu_mem_access #(.PROG_WORDS(PW)) cpu_mem_access_i (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_pc_inc(inc), .i_pc_load(load),
		.i_call(call), .i_ret(ret), .i_retfie(retfie), .i_irq_take(irq),
		.i_pc_target(target), .o_pc(pc), .i_stk_err_rst_en(err_en), .i_clr_ovf(clr_ovf),
		.i_clr_unf(clr_unf), .o_stack_overflow_flag(ovf), .o_stack_underflow_flag(unf),
		.o_soft_reset(srst), .i_ctx(ctx), .o_ctx_restore(ctx_r), .o_ctx_restore_valid(ctx_v),
		.i_ptr_wr(pwr), .i_ptr_wsel(pwsel), .i_ptr_whigh(pwhigh), .i_ptr_wdata(pwdata),
		.o_ptr0(p0), .o_ptr1(p1), .i_ind_req(req), .i_ind_sel(isel), .i_ind_we(iwe),
		.i_ind_wdata(iwdata), .o_ind_ready(rdy), .o_ind_rdata(rdata), .o_ind_done(done),
		.o_ind_wr_ignored(wign), .o_dmem_addr(daddr), .o_dmem_rd(drd), .o_dmem_we(dwe),
		.o_dmem_wdata(dwdata), .i_dmem_rdata(drdata), .o_pfm_addr(paddr), .o_pfm_rd(prd),
		.o_pfm_hef(phef), .i_pfm_rdata(prdata)
	);
	mem_partner mem_partner_i (
		.i_clk_sys(clk), .i_dmem_addr(daddr), .i_dmem_rd(drd), .o_dmem_rdata(drdata),
		.i_pfm_addr(paddr), .i_pfm_rd(prd), .o_pfm_rdata(prdata)
	);

	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("COUNTS compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			errors++;
		end
	endtask
	task automatic op(input logic [5:0] k, input pc_t t);
		@(posedge clk) #2;
		{irq, retfie, ret, call, load, inc} = k;
		target = t;
		@(posedge clk) #2;
		{irq, retfie, ret, call, load, inc} = 6'h00;
	endtask
	task automatic wptr(input logic s, input ptr_t v);
		for (int h = 0; h < 2; h++) begin
			@(posedge clk) #2;
			{pwr, pwsel, pwhigh} = {1'b1, s, h[0]};
			pwdata = h[0] ? v[15:8] : v[7:0];
			@(posedge clk) #2;
			pwr = 1'b0;
		end
	endtask
	// Records the strobes of the cycle after the request, then waits for done.
	task automatic ind(input logic s, input logic w, input logic [7:0] wd);
		@(posedge clk) #2;
		{req, isel, iwe} = {1'b1, s, w};
		iwdata = wd;
		@(posedge clk) #2;
		req = 1'b0;
		c1 = {drd, dwe, prd, phef};
		c1_rdy = rdy;
		c1_daddr = daddr;
		c1_paddr = paddr;
		c1_dw = dwdata;
		lat = 1;
		while (done !== 1'b1 && lat < 6) begin
			@(posedge clk) #2;
			lat++;
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		{irq, retfie, ret, call, load, inc} = 6'h00;
		{target, err_en, clr_ovf, clr_unf, ctx} = '0;
		{pwr, pwsel, pwhigh, pwdata, req, isel, iwe, iwdata} = '0;
		repeat (16) @(posedge clk);
		#2;
		chk("pc_reset", 15'h0000, pc);
		chk("ready_reset", 1'b1, rdy);
		chk("flags_reset", 2'b00, {ovf, unf});
		rst_b = 1'b1;
		$display("TEST reset done");
		op(K_LOAD, 15'h7ffe);
		chk("pc_wrap_load", 15'h7ffe & (PW - 1), pc);
		op(K_INC, 15'h0000);
		chk("pc_inc", 15'h03ff, pc);
		op(K_INC, 15'h0000);
		chk("pc_inc_wrap", 15'h0000, pc);
		// With the clock enable low an increment request must leave the counter alone.
		@(posedge clk) #2;
		{ce, inc} = 2'b01;
		repeat (3) @(posedge clk);
		#2;
		chk("ce_freeze", 15'h0000, pc);
		{ce, inc} = 2'b10;
		op(K_LOAD, 15'h0040);
		op(K_CALL, 15'h0123);
		chk("pc_call", 15'h0123, pc);
		op(K_RET, 15'h0000);
		chk("pc_ret", 15'h0041, pc);
		ctx = 32'h5a5a0f0f;
		op(K_IRQ, 15'h0000);
		chk("pc_irq", 15'h0004, pc);
		ctx = 32'h00000000;
		op(K_RETFIE, 15'h0000);
		chk("pc_retfie", 15'h0041, pc);
		chk("ctx_restore", 32'h5a5a0f0f, ctx_r);
		chk("ctx_valid", 1'b1, ctx_v);
		// A return right after a call takes the address that the call has just pushed.
		@(posedge clk) #2;
		{call, target} = {1'b1, 15'h0155};
		@(posedge clk) #2;
		{call, ret} = 2'b01;
		@(posedge clk) #2;
		ret = 1'b0;
		chk("pc_call_ret", 15'h0042, pc);
		$display("TEST program counter done");
		op(K_LOAD, 15'h0010);
		for (int j = 0; j < 16; j++) begin
			op(K_CALL, 15'(15'h0200 + j));
		end
		chk("ovf_full", 1'b0, ovf);
		op(K_CALL, 15'h0300);
		chk("ovf_set", 1'b1, ovf);
		for (int j = 15; j >= 0; j--) begin
			op(K_RET, 15'h0000);
			chk("pc_pop", (j > 0) ? 15'(15'h0200 + j) : 15'h0011, pc);
		end
		chk("unf_empty", 1'b0, unf);
		op(K_RET, 15'h0000);
		chk("unf_set", 1'b1, unf);
		chk("pc_unf", 15'h0000, pc);
		chk("srst_off", 1'b0, srst);
		chk("ovf_sticky", 1'b1, ovf);
		@(posedge clk) #2;
		{clr_ovf, clr_unf} = 2'b11;
		@(posedge clk) #2;
		{clr_ovf, clr_unf} = 2'b00;
		chk("flags_clear", 2'b00, {ovf, unf});
		err_en = 1'b1;
		op(K_RET, 15'h0000);
		chk("srst_pulse", 1'b1, srst);
		@(posedge clk) #2;
		chk("srst_end", 1'b0, srst);
		// Seventeen calls overflow the stack and, with the option on, reset the core.
		for (int j = 0; j < 17; j++) begin
			op(K_CALL, 15'h0222);
		end
		chk("srst_ovf", {1'b1, 1'b1, 15'h0000}, {srst, ovf, pc});
		err_en = 1'b0;
		$display("TEST stack done");
		wptr(1'b0, 16'h0123);
		chk("ptr0", 16'h0123, p0);
		ind(1'b0, 1'b0, 8'h00);
		chk("dmem_lat", 2, lat);
		chk("dmem_addr", 12'h123, c1_daddr);
		chk("dmem_strobes", 4'b1000, c1);
		chk("dmem_rdata", 8'h23 ^ 8'h5a, rdata);
		ind(1'b0, 1'b1, 8'ha5);
		chk("dmem_wr", {4'b0100, 8'ha5}, {c1, c1_dw});
		wptr(1'b1, 16'h2055);
		chk("ptr1", 16'h2055, p1);
		ind(1'b1, 1'b0, 8'h00);
		chk("lin_addr", 12'h0a5, c1_daddr);
		chk("lin_rdata", 8'ha5 ^ 8'h5a, rdata);
		wptr(1'b1, 16'h83fa);
		ind(1'b1, 1'b0, 8'h00);
		chk("pfm_lat", 3, lat);
		chk("pfm_busy", 1'b0, c1_rdy);
		chk("pfm_strobes", 4'b0011, c1);
		chk("pfm_addr", 15'h03fa, c1_paddr);
		chk("pfm_rdata", 8'(14'h03fa ^ 14'h2c95), rdata);
		wptr(1'b0, 16'h8500);
		ind(1'b0, 1'b0, 8'h00);
		chk("pfm_wrap", {4'b0010, 15'h0100}, {c1, c1_paddr});
		chk("pfm_rdata2", 8'(14'h0100 ^ 14'h2c95), rdata);
		ind(1'b1, 1'b1, 8'h3c);
		chk("pfm_wr_lat", 3, lat);
		chk("pfm_wr_strobes", 3'b000, c1[3:1]);
		chk("pfm_wr_ignored", {1'b1, 8'h00}, {wign, rdata});
		$display("TEST indirect port done");
		finish_test();
	end
endmodule
`default_nettype wire
